// ==== pkg/mdp_defines.svh ====
// Purpose: timing and reset constants for the mac data port block
// Assumes: ref_clk at 20 MHz
// Notes: link clock half periods are counts of ref_clk cycles
`ifndef MDP_DEFINES_SVH
`define MDP_DEFINES_SVH

// core clock
`define MDP_REF_MHZ 16'h0014
// sqe heartbeat length, nanoseconds, and derived cycle count (rounded down)
`define MDP_SQE_NS 16'h03E8
`define MDP_SQE_CYC ((`MDP_SQE_NS * `MDP_REF_MHZ) / 16'h03E8)
// half periods of the generated link clock, in ref_clk cycles
`define MDP_HALF_MII100 4'h1
`define MDP_HALF_MII10 4'hA
`define MDP_HALF_RMII 4'h1
// reset values
`define MDP_RXD_RST 4'h0
`define MDP_CNT_RST 4'h0

`endif

// ==== pkg/mdp_pkg.sv ====
// Purpose: shared types of the mac data port block
// Assumes: nothing beyond SystemVerilog packages
// Notes: constants live in mdp_defines.svh
`default_nettype none

package mdp_pkg;

  // strapped or configured operating mode
  typedef struct packed {
    logic rmii;
    logic master;
    logic speed100;
    logic full_duplex;
    logic hb_en;
  } mdp_cfg_t;

  // receive symbols delivered by the line decoder
  typedef struct packed {
    logic active;
    logic valid;
    logic err;
    logic [3:0] data;
  } mdp_line_rx_t;

  // transmit symbols handed to the line encoder
  typedef struct packed {
    logic valid;
    logic [3:0] data;
  } mdp_line_tx_t;

endpackage

`default_nettype wire

// ==== rtl/mdp_data_port.sv ====
// Purpose: phy side of the mii / rmii mac data interface
// Assumes: one core clock; mac pins and mode straps synchronised here
// Notes: link clocks are generated by division of ref_clk; see defines
`timescale 1ns/100ps
`default_nettype none
`include "mdp_defines.svh"

module mdp_data_port
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire mdp_pkg::mdp_cfg_t cfg_pins,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  input wire mdp_pkg::mdp_line_rx_t line_rx,
  output mdp_pkg::mdp_line_tx_t line_tx,
  output logic tx_clk,
  output logic rx_clk,
  output logic rx_dv,
  output logic rx_er,
  output logic [3:0] rxd,
  output logic crs_crs_dv,
  output logic col
);

  localparam int SYNC_W = 10;
  localparam logic [4:0] SQE_CYC = 5'(`MDP_SQE_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: straps and mac pins come from outside this clock

  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  mdp_pkg::mdp_cfg_t cfg;
  logic tx_en_s;
  logic [3:0] txd_s;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {cfg_pins, tx_en, txd};
      sync2_q <= sync1_q;
    end
  end

  assign cfg = mdp_pkg::mdp_cfg_t'(sync2_q[9:5]);
  assign tx_en_s = sync2_q[4];
  assign txd_s = sync2_q[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // link clock divider; rise is the one-cycle enable for every transfer

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic lclk_q;
  logic lclk_d;
  logic rise;
  logic [3:0] half;

  // half period picked from the current mode
  always_comb
  begin
    if (cfg.rmii)
      half = `MDP_HALF_RMII;
    else if (cfg.speed100)
      half = `MDP_HALF_MII100;
    else
      half = `MDP_HALF_MII10;
    cnt_d = cnt_q + 4'h1;
    lclk_d = lclk_q;
    rise = 1'b0;
    // >= rather than == so a shorter half period after a mode change still wraps
    if (cnt_q >= half - 4'h1)
    begin
      cnt_d = `MDP_CNT_RST;
      lclk_d = !lclk_q;
      rise = !lclk_q;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q <= `MDP_CNT_RST;
      lclk_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      lclk_q <= lclk_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock pins: mii rates, rmii master reference, idle in rmii slave

  logic clk_out_d;
  logic tx_clk_q;
  logic rx_clk_q;

  // slave mode leaves the pins low; the mac uses its own reference
  always_comb
  begin
    clk_out_d = lclk_d;
    if (cfg.rmii && !cfg.master)
      clk_out_d = 1'b0;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_clk_q <= 1'b0;
      rx_clk_q <= 1'b0;
    end
    else
    begin
      tx_clk_q <= clk_out_d;
      rx_clk_q <= clk_out_d;
    end
  end

  assign tx_clk = tx_clk_q;
  assign rx_clk = rx_clk_q;

  ////////////////////////////////////////////////////////////////////////////
  // transmit capture toward the line encoder

  mdp_pkg::mdp_line_tx_t tx_q;
  mdp_pkg::mdp_line_tx_t tx_d;

  // sampled only on the link clock rise, so mac launch is at least one full period old
  always_comb
  begin
    tx_d = tx_q;
    if (rise)
    begin
      tx_d.valid = tx_en_s;
      tx_d.data = 4'h0;
      if (tx_en_s && cfg.rmii)
        tx_d.data = {2'b00, txd_s[1:0]};
      else if (tx_en_s)
        tx_d.data = txd_s;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      tx_q <= '0;
    else
      tx_q <= tx_d;
  end

  assign line_tx = tx_q;

  ////////////////////////////////////////////////////////////////////////////
  // receive path: data, valid, error and carrier

  logic rx_dv_q;
  logic rx_dv_d;
  logic rx_er_q;
  logic rx_er_d;
  logic [3:0] rxd_q;
  logic [3:0] rxd_d;
  logic crs_q;
  logic crs_d;
  logic alt_q;
  logic alt_d;

  // rmii crs_dv toggles on alternate dibits once carrier is gone
  always_comb
  begin
    rx_dv_d = rx_dv_q;
    rx_er_d = rx_er_q;
    rxd_d = rxd_q;
    crs_d = crs_q;
    alt_d = alt_q;
    if (rise)
    begin
      rx_dv_d = line_rx.valid;
      rx_er_d = cfg.speed100 && line_rx.valid && line_rx.err;
      rxd_d = `MDP_RXD_RST;
      if (line_rx.valid && cfg.rmii)
      begin
        rxd_d = {2'b00, line_rx.data[1:0]};
        if (line_rx.err)
          rxd_d = {2'b00, ~line_rx.data[1:0]};
      end
      else if (line_rx.valid)
        rxd_d = line_rx.data;
      alt_d = line_rx.valid && !line_rx.active && !alt_q;
      if (!cfg.rmii)
        crs_d = line_rx.active;
      else
        crs_d = line_rx.active || (line_rx.valid && !alt_q);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_dv_q <= 1'b0;
      rx_er_q <= 1'b0;
      rxd_q <= `MDP_RXD_RST;
      crs_q <= 1'b0;
      alt_q <= 1'b0;
    end
    else
    begin
      rx_dv_q <= rx_dv_d;
      rx_er_q <= rx_er_d;
      rxd_q <= rxd_d;
      crs_q <= crs_d;
      alt_q <= alt_d;
    end
  end

  assign rx_dv = rx_dv_q;
  assign rx_er = rx_er_q;
  assign rxd = rxd_q;
  assign crs_crs_dv = crs_q;

  ////////////////////////////////////////////////////////////////////////////
  // collision and sqe heartbeat

  logic tx_prev_q;
  logic [4:0] sqe_q;
  logic [4:0] sqe_d;
  logic col_q;
  logic col_d;
  logic half_mii;

  // rmii has no collision pin; the mac derives it from crs_dv
  assign half_mii = !cfg.rmii && !cfg.full_duplex;

  // col is registered, so it trails the overlap by one ref_clk cycle
  always_comb
  begin
    sqe_d = sqe_q;
    if (sqe_q != 5'h00)
      sqe_d = sqe_q - 5'h01;
    if (tx_prev_q && !tx_en_s && half_mii && !cfg.speed100 && cfg.hb_en)
      sqe_d = SQE_CYC;
    col_d = half_mii && ((tx_en_s && line_rx.active) || sqe_q != 5'h00);
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_prev_q <= 1'b0;
      sqe_q <= 5'h00;
      col_q <= 1'b0;
    end
    else
    begin
      tx_prev_q <= tx_en_s;
      sqe_q <= sqe_d;
      col_q <= col_d;
    end
  end

  assign col = col_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // held outputs only move on rise, so data checks look one cycle after it
  full_dup_col_a: assert property (cfg.full_duplex |=> !col_q)
    else $error("collision while full duplex");
  rmii_col_a: assert property (cfg.rmii |=> !col_q)
    else $error("collision driven in rmii");
  slave_clk_a: assert property (cfg.rmii && !cfg.master |=> !tx_clk_q && !rx_clk_q)
    else $error("clock pin driven in rmii slave");
  rx_er_valid_a: assert property (rise |=>
    !rx_er_q || (rx_dv_q && $past(cfg.speed100)))
    else $error("receive error without valid data");
  rxd_idle_a: assert property (!rx_dv_q |-> rxd_q == 4'h0)
    else $error("receive data without valid");
  tx_gate_a: assert property (rise |=> tx_q.valid == $past(tx_en_s))
    else $error("transmit accepted without enable");
  rx_on_rise_a: assert property ($changed(rxd_q) |-> $past(rise))
    else $error("receive data changed off the clock edge");
  sqe_pulse_a: assert property ($fell(tx_en_s) && half_mii && !cfg.speed100 && cfg.hb_en
    && $stable(cfg) |-> ##2 col_q [*8])
    else $error("heartbeat pulse too short");
  rmii_hi_a: assert property (cfg.rmii && rise |=> rxd_q[3:2] == 2'b00)
    else $error("upper receive bits used in rmii");
  mii_crs_a: assert property (!cfg.rmii && rise |=> crs_q == $past(line_rx.active))
    else $error("carrier sense does not follow the medium");
  rmii_tx_hi_a: assert property (cfg.rmii && rise |=> tx_q.data[3:2] == 2'b00)
    else $error("upper transmit bits used in rmii");
  rmii_corrupt_a: assert property (cfg.rmii && rise && line_rx.valid && line_rx.err
    |=> rxd_q[1:0] == ~$past(line_rx.data[1:0]))
    else $error("receive dibit not corrupted on error");

  // main scenarios a run should reach
  heartbeat_c: cover property ($fell(tx_en_s) ##2 col_q);
  master_clk_c: cover property (cfg.rmii && cfg.master && rise);
  collision_c: cover property (tx_en_s && line_rx.active ##2 col_q);
  rmii_err_c: cover property (cfg.rmii && rx_er_q);
  crs_dv_toggle_c: cover property (cfg.rmii && rx_dv_q && !crs_q);

endmodule // mdp_data_port

`default_nettype wire

// ==== verif/mdp_data_port_tb.sv ====
// Purpose: self-checking bench for the mac data port
// Assumes: waits of 60 cycles cover sync plus two slow link periods
// Notes: the bench drives the line decoder side directly
`timescale 1ns/100ps
`default_nettype none
`include "mdp_defines.svh"

module mdp_data_port_tb;
  logic ref_clk, reset_n, req_en, tx_en, tx_clk, rx_clk, rx_dv, rx_er, crs, col, mac_col;
  logic [3:0] req_data, txd, rxd;
  mdp_pkg::mdp_cfg_t cfg;
  mdp_pkg::mdp_line_rx_t lrx;
  mdp_pkg::mdp_line_tx_t ltx;
  int n_fail, compares, cyc, n;
  realtime t;

  mdp_data_port mdp_data_port_inst (.ref_clk(ref_clk), .reset_n(reset_n), .cfg_pins(cfg),
    .tx_en(tx_en), .txd(txd), .line_rx(lrx), .line_tx(ltx), .tx_clk(tx_clk),
    .rx_clk(rx_clk), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd), .crs_crs_dv(crs), .col(col));
  mdp_mac_model mdp_mac_model_inst (.ref_clk(ref_clk), .slave(cfg.rmii & ~cfg.master),
    .tx_clk(tx_clk), .req_en(req_en), .req_data(req_data), .crs_crs_dv(crs),
    .tx_en(tx_en), .txd(txd), .mac_col(mac_col));

  ////////////////////////////////////////////////////////////////////////////
  // system reference; 20 MHz stands in for the 25 or 50 MHz input
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // hang guard, far above the roughly 1600 cycles needed
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done();
    end
  end

  task automatic test_done();
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // apply stimulus after the edge, then let it settle
  task automatic step(input logic en, input logic [3:0] d, input logic [6:0] rx);
    @(posedge ref_clk);
    #1;
    req_en = en;
    req_data = d;
    lrx = rx;
    repeat (60) @(posedge ref_clk);
    #1;
  endtask

  // quiet both directions in the old mode first, so nothing is in flight
  task automatic mode(input logic [4:0] c);
    step(1'b0, 4'h0, 7'h00);
    cfg = c;
    repeat (60) @(posedge ref_clk);
    #1;
  endtask

  // period of both link clock pins in ref_clk cycles
  task automatic per(input int exp);
    @(posedge tx_clk);
    t = $realtime;
    @(posedge tx_clk);
    chk("tx_clk period", 8'(int'(($realtime - t) / 50.0)), 8'(exp));
    @(posedge rx_clk);
    t = $realtime;
    @(posedge rx_clk);
    chk("rx_clk period", 8'(int'(($realtime - t) / 50.0)), 8'(exp));
  endtask

  // count cycles of col high after transmit enable drops
  task automatic hb(input int exp);
    step(1'b1, 4'h1, 7'h00);
    req_en = 1'b0;
    n = 0;
    repeat (80)
    begin
      @(posedge ref_clk);
      #1;
      n += int'(col === 1'b1);
    end
    chk("sqe length", 8'(n), 8'(exp));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    reset_n = 1'b0;
    cfg = 5'h04;
    lrx = 7'h00;
    req_en = 1'b0;
    req_data = 4'h0;
    repeat (4) @(posedge ref_clk);
    #1;
    chk("reset outs", {1'h0, tx_clk, rx_clk, rx_dv, rx_er, crs, col, ltx.valid}, 8'h00);
    repeat (4) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    // mii 100 half duplex, then full duplex
    mode(5'h04);
    per(2);
    step(1'b1, 4'hA, 7'h00);
    chk("line_tx", {3'h0, ltx}, 8'h1A);
    chk("col idle", {7'h0, col}, 8'h00);
    step(1'b1, 4'hA, 7'h75);
    chk("col", {7'h0, col}, 8'h01);
    chk("rx", {1'h0, rx_dv, rx_er, crs, rxd}, 8'h75);
    step(1'b0, 4'hF, 7'h00);
    chk("line_tx idle", {3'h0, ltx}, 8'h00);
    chk("rx idle", {6'h0, rx_dv, crs}, 8'h00);
    mode(5'h06);
    step(1'b1, 4'h3, 7'h75);
    chk("col full", {7'h0, col}, 8'h00);
    // mii 10 half duplex with heartbeat, then full duplex without it
    mode(5'h01);
    per(20);
    step(1'b1, 4'hC, 7'h75);
    chk("rx 10", {1'h0, rx_dv, rx_er, crs, rxd}, 8'h55);
    chk("line_tx 10", {3'h0, ltx}, 8'h1C);
    hb(`MDP_SQE_CYC);
    mode(5'h03);
    hb(0);
    // rmii slave: pins quiet, error corrupts the dibit
    mode(5'h14);
    n = 0;
    repeat (40)
    begin
      @(posedge ref_clk);
      #1;
      n += int'(tx_clk | rx_clk);
    end
    chk("slave clocks", 8'(n), 8'h00);
    step(1'b1, 4'hF, 7'h32);
    chk("rmii rx", {2'h0, rx_dv, rx_er, rxd}, 8'h31);
    chk("rmii tx", {3'h0, ltx}, 8'h13);
    // no carrier, data still valid: crs_dv alternates each dibit
    n = 0;
    repeat (20)
    begin
      @(posedge ref_clk);
      #1;
      n += int'(crs === 1'b1);
    end
    chk("crs_dv toggle", 8'(n), 8'h0A);
    step(1'b1, 4'h0, 7'h65);
    chk("crs_dv", {6'h0, crs, mac_col}, 8'h03);
    mode(5'h1C);
    per(2);
    test_done();
  end
endmodule // mdp_data_port_tb

`default_nettype wire

// ==== verif/mdp_mac_model.sv ====
// Purpose: mac side model facing the data port
// Assumes: launches on the link clock pin, or ref_clk in rmii slave
// Notes: idle data toggles so stale values never pass for real ones
`timescale 1ns/100ps
`default_nettype none

module mdp_mac_model
(
  input wire logic ref_clk,
  input wire logic slave,
  input wire logic tx_clk,
  input wire logic req_en,
  input wire logic [3:0] req_data,
  input wire logic crs_crs_dv,
  output logic tx_en,
  output logic [3:0] txd,
  output logic mac_col
);
  wire logic lclk = slave ? ref_clk : tx_clk;

  ////////////////////////////////////////////////////////////////////////////
  // launch just after the link clock rise, hold for the whole period
  initial
  begin
    tx_en = 1'b0;
    txd = 4'h0;
  end
  always @(posedge lclk)
  begin
    #1;
    tx_en = req_en;
    txd = req_en ? req_data : ~txd;
  end

  // no collision pin in rmii, so derive it here
  assign mac_col = crs_crs_dv & tx_en;
endmodule // mdp_mac_model

`default_nettype wire
